// ===== hdl/rfca_pkg.sv
// Purpose: constants for the receive credit advertisement block
// Assumes: each channel credit vector is 56 bits wide
// Notes:   field positions and sizes are fixed by the credit vector layout

package rfca_pkg;

  // ---------------------------------------------------------------
  // credit vector layout
  // ---------------------------------------------------------------
  localparam int VEC_W   = 56;
  localparam int PH_LO   = 0;
  localparam int PH_HI   = 7;
  localparam int PD_LO   = 8;
  localparam int PD_HI   = 19;
  localparam int NPH_LO  = 20;
  localparam int NPH_HI  = 27;
  localparam int NPD_LO  = 28;
  localparam int NPD_HI  = 35;
  localparam int CPLH_LO = 36;
  localparam int CPLH_HI = 43;
  localparam int CPLD_LO = 44;
  localparam int CPLD_HI = 55;

  localparam int HDR_W   = 8;
  localparam int DAT_W   = 12;
  localparam int MAX_VC  = 4;
  localparam int IDX_W   = 2;

  // ---------------------------------------------------------------
  // advertised values
  // ---------------------------------------------------------------
  // a zero field on the wire means an unlimited credit
  localparam logic [HDR_W-1:0] HDR_INFINITE = 8'h00;
  localparam logic [DAT_W-1:0] DAT_INFINITE = 12'h000;
  localparam logic [IDX_W-1:0] IDX_FIRST    = 2'h0;
  localparam logic [IDX_W-1:0] IDX_STEP     = 2'h1;

  // ---------------------------------------------------------------
  // initialisation sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_SEND = 3'h2,
    S_DONE = 3'h4
  } rfca_state_t;

endpackage

// ===== hdl/rfca_fields_if.sv
// Purpose: carries one channel's credit vector and its decoded fields
// Assumes: one instance per virtual channel
// Notes:   the lane modport decodes, the user modport consumes

`timescale 1ns/1ns

interface rfca_fields_if;
  logic [rfca_pkg::VEC_W-1:0] vec;
  logic [rfca_pkg::HDR_W-1:0] ph;
  logic [rfca_pkg::DAT_W-1:0] pd;
  logic [rfca_pkg::HDR_W-1:0] nph;
  logic [rfca_pkg::HDR_W-1:0] npd;
  logic [rfca_pkg::HDR_W-1:0] cplh;
  logic [rfca_pkg::DAT_W-1:0] cpld;
  logic                       fault;

  modport lane (input vec, output ph, pd, nph, npd, cplh, cpld, fault);
  modport user (output vec, input ph, pd, nph, npd, cplh, cpld, fault);
endinterface

// ===== hdl/rfca_lane.sv
// Purpose: decodes one channel credit vector into advertised fields
// Assumes: vector is static configuration, sampled synchronously upstream
// Notes:   fields that must be zero are forced; a nonzero input is flagged

`timescale 1ns/1ns

module rfca_lane (
  rfca_fields_if.lane f
);

  // ---------------------------------------------------------------
  // configured fields
  // ---------------------------------------------------------------
  assign f.ph  = f.vec[rfca_pkg::PH_HI:rfca_pkg::PH_LO];    // R1
  assign f.pd  = f.vec[rfca_pkg::PD_HI:rfca_pkg::PD_LO];    // R2
  assign f.nph = f.vec[rfca_pkg::NPH_HI:rfca_pkg::NPH_LO];  // R3

  // ---------------------------------------------------------------
  // fields held at zero
  // ---------------------------------------------------------------
  // forcing beats trusting the vector: a bad value never reaches the wire
  assign f.npd  = rfca_pkg::HDR_INFINITE;  // R4 R5
  assign f.cplh = rfca_pkg::HDR_INFINITE;  // R6
  assign f.cpld = rfca_pkg::DAT_INFINITE;  // R7

  // flag any forced field that arrived nonzero
  assign f.fault = (|f.vec[rfca_pkg::NPD_HI:rfca_pkg::NPD_LO])
                 | (|f.vec[rfca_pkg::CPLH_HI:rfca_pkg::CPLH_LO])
                 | (|f.vec[rfca_pkg::CPLD_HI:rfca_pkg::CPLD_LO]);

endmodule

// ===== hdl/rfca_top.sv
// Purpose: advertises receive flow-control credits for up to four channels
// Assumes: credit vectors are static, synchronous to clk
// Notes:   one advertisement per channel, one channel per cycle, after fc_init_start
//
// Notes on behaviour
// R1: posted-header credit comes from vector bits 7:0 of each channel.
// R2: posted-data credit comes from the twelve-bit field at bits 19:8.
// R3: non-posted-header credit comes from vector bits 27:20.
// R4: channel zero non-posted data is zero; buffer always holds one doubleword.
// R5: only channel zero carries config or I/O writes; others advertise zero.
// R6: completion-header field is held at zero, meaning unlimited, on every channel.
// R7: completion-data field is held at zero so completion data is infinite.
// R8: zero completion fields advertise infinite; completions are never blocked.

`timescale 1ns/1ns

module rfca_top #(
  parameter int NUM_VC = rfca_pkg::MAX_VC
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [rfca_pkg::VEC_W-1:0]   channel_zero_credit_vector,
  input  wire logic [rfca_pkg::VEC_W-1:0]   channel_one_credit_vector,
  input  wire logic [rfca_pkg::VEC_W-1:0]   channel_two_credit_vector,
  input  wire logic [rfca_pkg::VEC_W-1:0]   channel_three_credit_vector,
  input  wire logic                         fc_init_start,
  output logic                              adv_valid,
  output logic [rfca_pkg::IDX_W-1:0]        adv_channel,
  output logic [rfca_pkg::HDR_W-1:0]        adv_ph,
  output logic [rfca_pkg::DAT_W-1:0]        adv_pd,
  output logic [rfca_pkg::HDR_W-1:0]        adv_nph,
  output logic [rfca_pkg::HDR_W-1:0]        adv_npd,
  output logic [rfca_pkg::HDR_W-1:0]        adv_cplh,
  output logic [rfca_pkg::DAT_W-1:0]        adv_cpld,
  output logic                              adv_cpl_infinite,
  output logic                              fc_init_done,
  output logic                              cfg_fault,
  output logic                              rx_cpl_ready
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_VC < 1 || NUM_VC > rfca_pkg::MAX_VC) begin : g_bad_vc
    $error("NUM_VC must lie between 1 and 4");
  end

  localparam logic [rfca_pkg::IDX_W-1:0] LAST_IDX = rfca_pkg::IDX_W'(NUM_VC - 1);

  // ---------------------------------------------------------------
  // per-channel decode
  // ---------------------------------------------------------------
  logic [rfca_pkg::VEC_W-1:0] vec_all  [rfca_pkg::MAX_VC];
  logic [rfca_pkg::HDR_W-1:0] ph_arr   [rfca_pkg::MAX_VC];
  logic [rfca_pkg::DAT_W-1:0] pd_arr   [rfca_pkg::MAX_VC];
  logic [rfca_pkg::HDR_W-1:0] nph_arr  [rfca_pkg::MAX_VC];
  logic [rfca_pkg::HDR_W-1:0] npd_arr  [rfca_pkg::MAX_VC];
  logic [rfca_pkg::HDR_W-1:0] cplh_arr [rfca_pkg::MAX_VC];
  logic [rfca_pkg::DAT_W-1:0] cpld_arr [rfca_pkg::MAX_VC];
  logic [rfca_pkg::MAX_VC-1:0] fault_vec;

  assign vec_all[0] = channel_zero_credit_vector;
  assign vec_all[1] = channel_one_credit_vector;
  assign vec_all[2] = channel_two_credit_vector;
  assign vec_all[3] = channel_three_credit_vector;

  // one decoder per channel; unused channels still decode but are never sent
  for (genvar g = 0; g < rfca_pkg::MAX_VC; g++) begin : g_lane
    rfca_fields_if fif ();
    assign fif.vec   = vec_all[g];
    assign ph_arr[g]   = fif.ph;
    assign pd_arr[g]   = fif.pd;
    assign nph_arr[g]  = fif.nph;
    assign npd_arr[g]  = fif.npd;
    assign cplh_arr[g] = fif.cplh;
    assign cpld_arr[g] = fif.cpld;
    assign fault_vec[g] = (g < NUM_VC) ? fif.fault : 1'b0;
    rfca_lane u_lane (
      .f (fif.lane)
    );
  end

  // ---------------------------------------------------------------
  // initialisation sequencer and advertisement registers
  // ---------------------------------------------------------------
  rfca_pkg::rfca_state_t      state;
  rfca_pkg::rfca_state_t      next_state;
  logic [rfca_pkg::IDX_W-1:0] idx;
  logic [rfca_pkg::IDX_W-1:0] next_idx;
  logic                       next_adv_valid;
  logic [rfca_pkg::IDX_W-1:0] next_adv_channel;
  logic [rfca_pkg::HDR_W-1:0] next_adv_ph;
  logic [rfca_pkg::DAT_W-1:0] next_adv_pd;
  logic [rfca_pkg::HDR_W-1:0] next_adv_nph;
  logic [rfca_pkg::HDR_W-1:0] next_adv_npd;
  logic [rfca_pkg::HDR_W-1:0] next_adv_cplh;
  logic [rfca_pkg::DAT_W-1:0] next_adv_cpld;
  logic                       next_adv_cpl_infinite;
  logic                       next_fc_init_done;
  logic                       next_cfg_fault;
  logic                       next_rx_cpl_ready;

  // walk the channels once per start; a start while sending is ignored
  always_comb begin
    next_state = state;
    next_idx   = idx;
    case (state)
      rfca_pkg::S_IDLE, rfca_pkg::S_DONE: begin
        if (fc_init_start) begin
          next_state = rfca_pkg::S_SEND;
          next_idx   = rfca_pkg::IDX_FIRST;
        end
      end
      rfca_pkg::S_SEND: begin
        if (idx == LAST_IDX) begin
          next_state = rfca_pkg::S_DONE;
        end else begin
          next_idx = idx + rfca_pkg::IDX_STEP;
        end
      end
      default: begin
        next_state = rfca_pkg::S_IDLE;
        next_idx   = rfca_pkg::IDX_FIRST;
      end
    endcase
    next_adv_valid        = (state == rfca_pkg::S_SEND);
    next_adv_channel      = idx;
    next_adv_ph           = ph_arr[idx];    // R1
    next_adv_pd           = pd_arr[idx];    // R2
    next_adv_nph          = nph_arr[idx];   // R3
    next_adv_npd          = npd_arr[idx];   // R4 R5
    next_adv_cplh         = cplh_arr[idx];  // R6
    next_adv_cpld         = cpld_arr[idx];  // R7
    // zero completion fields go out flagged as unlimited
    next_adv_cpl_infinite = (cplh_arr[idx] == rfca_pkg::HDR_INFINITE)
                          && (cpld_arr[idx] == rfca_pkg::DAT_INFINITE);  // R8
    next_fc_init_done     = (next_state == rfca_pkg::S_DONE);
    next_cfg_fault        = |fault_vec;
    // completions always have room, so the sink never stalls them
    next_rx_cpl_ready     = 1'b1;  // R8
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state            <= rfca_pkg::S_IDLE;
      idx              <= rfca_pkg::IDX_FIRST;
      adv_valid        <= 1'b0;
      adv_channel      <= rfca_pkg::IDX_FIRST;
      adv_ph           <= rfca_pkg::HDR_INFINITE;
      adv_pd           <= rfca_pkg::DAT_INFINITE;
      adv_nph          <= rfca_pkg::HDR_INFINITE;
      adv_npd          <= rfca_pkg::HDR_INFINITE;
      adv_cplh         <= rfca_pkg::HDR_INFINITE;
      adv_cpld         <= rfca_pkg::DAT_INFINITE;
      adv_cpl_infinite <= 1'b0;
      fc_init_done     <= 1'b0;
      cfg_fault        <= 1'b0;
      rx_cpl_ready     <= 1'b1;
    end else begin
      state            <= next_state;
      idx              <= next_idx;
      adv_valid        <= next_adv_valid;
      adv_channel      <= next_adv_channel;
      adv_ph           <= next_adv_ph;
      adv_pd           <= next_adv_pd;
      adv_nph          <= next_adv_nph;
      adv_npd          <= next_adv_npd;
      adv_cplh         <= next_adv_cplh;
      adv_cpld         <= next_adv_cpld;
      adv_cpl_infinite <= next_adv_cpl_infinite;
      fc_init_done     <= next_fc_init_done;
      cfg_fault        <= next_cfg_fault;
      rx_cpl_ready     <= next_rx_cpl_ready;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ph_from_vec: assert property (  // R1
    @(posedge clk) disable iff (!rst_b)
    (state == rfca_pkg::S_SEND) |=> adv_valid && (adv_channel == $past(idx))
      && (adv_ph == $past(vec_all[idx][rfca_pkg::PH_HI:rfca_pkg::PH_LO])))
    else $error("posted header credit does not match its vector field");

  a_pd_from_vec: assert property (  // R2
    @(posedge clk) disable iff (!rst_b)
    (state == rfca_pkg::S_SEND)
      |=> (adv_pd == $past(vec_all[idx][rfca_pkg::PD_HI:rfca_pkg::PD_LO])))
    else $error("posted data credit does not match its vector field");

  a_nph_from_vec: assert property (  // R3
    @(posedge clk) disable iff (!rst_b)
    (state == rfca_pkg::S_SEND)
      |=> (adv_nph == $past(vec_all[idx][rfca_pkg::NPH_HI:rfca_pkg::NPH_LO])))
    else $error("non-posted header credit does not match its vector field");

  a_npd_zero_ch0: assert property (  // R4
    @(posedge clk) disable iff (!rst_b)
    (adv_valid && adv_channel == rfca_pkg::IDX_FIRST) |-> (adv_npd == rfca_pkg::HDR_INFINITE))
    else $error("channel zero non-posted data credit is not zero");

  a_npd_fault_hi: assert property (  // R5
    @(posedge clk) disable iff (!rst_b)
    (NUM_VC > 1 && |vec_all[1][rfca_pkg::NPD_HI:rfca_pkg::NPD_LO])
      |=> cfg_fault ##0 (!adv_valid || adv_npd == rfca_pkg::HDR_INFINITE))
    else $error("nonzero non-posted data on upper channel not flagged or leaked");

  a_cplh_zero: assert property (  // R6
    @(posedge clk) disable iff (!rst_b)
    adv_valid |-> (adv_cplh == rfca_pkg::HDR_INFINITE))
    else $error("completion header credit is not zero");

  a_cpld_zero: assert property (  // R7
    @(posedge clk) disable iff (!rst_b)
    adv_valid |-> (adv_cpld == rfca_pkg::DAT_INFINITE) && adv_cpl_infinite)
    else $error("completion data credit is not advertised infinite");

  a_cpl_unblocked: assert property (  // R8
    @(posedge clk) disable iff (!rst_b)
    (state == rfca_pkg::S_IDLE && fc_init_start)
      |=> rx_cpl_ready throughout (##1 adv_valid [*4] ##1 fc_init_done))
    else $error("init sequence wrong or completions blocked");

endmodule

// ===== bench/rfca_link_partner.sv
// Purpose: far-end model that records the credit advertisements it receives
// Assumes: advertisements arrive in channel order, one per cycle
// Notes:   it only listens; the block takes nothing back from the link partner

`timescale 1ns/1ns

module rfca_link_partner (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        adv_valid,
  input  wire logic [1:0]  adv_channel,
  input  wire logic [7:0]  adv_ph,
  input  wire logic [11:0] adv_pd,
  input  wire logic [7:0]  adv_nph,
  input  wire logic [7:0]  adv_npd,
  input  wire logic [7:0]  adv_cplh,
  input  wire logic [11:0] adv_cpld,
  input  wire logic        adv_cpl_infinite
);
  // ---------------------------------------------------------------
  // capture of received advertisements
  // ---------------------------------------------------------------
  logic [55:0] seen [4];
  int          n_adv;
  logic        proto_bad;
  logic [1:0]  next_ch;

  // config and io writes are only ever sent on channel zero, so a nonzero
  // non-posted data credit elsewhere would be a protocol slip
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n_adv     <= 0;
      proto_bad <= 1'b0;
      next_ch   <= 2'h0;
    end else if (adv_valid) begin
      seen[adv_channel] <= {adv_cpld, adv_cplh, adv_npd, adv_nph, adv_pd, adv_ph};
      n_adv             <= n_adv + 1;
      next_ch           <= adv_channel + 2'h1;
      if (adv_channel !== next_ch || adv_cpl_infinite !== 1'b1 ||
          (adv_channel != 2'h0 && adv_npd != 8'h00)) begin
        proto_bad <= 1'b1;
      end
    end
  end
endmodule

// ===== bench/rx_flow_credit_advertise_cfg_bench.sv
// Purpose: self-checking bench for the receive credit advertisement block
// Assumes: four channels, vectors changed only while no init runs
// Notes:   expected fields are built here from the vector layout

`timescale 1ns/1ns

module rx_flow_credit_advertise_cfg_bench;
  // ---------------------------------------------------------------
  // stimulus and bookkeeping
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        fc_init_start = 1'b0;
  logic [55:0] v [4] = '{default: 56'h0};
  logic        adv_valid, adv_cpl_infinite, fc_init_done, cfg_fault, rx_cpl_ready;
  logic [1:0]  adv_channel;
  logic [7:0]  adv_ph, adv_nph, adv_npd, adv_cplh;
  logic [11:0] adv_pd, adv_cpld;
  int          errors = 0;
  int          checks_done = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  rfca_top #(.NUM_VC(4)) u_rfca_top (.clk(clk), .rst_b(rst_b),
    .channel_zero_credit_vector(v[0]), .channel_one_credit_vector(v[1]),
    .channel_two_credit_vector(v[2]), .channel_three_credit_vector(v[3]),
    .fc_init_start(fc_init_start), .adv_valid(adv_valid), .adv_channel(adv_channel),
    .adv_ph(adv_ph), .adv_pd(adv_pd), .adv_nph(adv_nph), .adv_npd(adv_npd),
    .adv_cplh(adv_cplh), .adv_cpld(adv_cpld), .adv_cpl_infinite(adv_cpl_infinite),
    .fc_init_done(fc_init_done), .cfg_fault(cfg_fault), .rx_cpl_ready(rx_cpl_ready));

  rfca_link_partner u_rfca_link_partner (.clk(clk), .rst_b(rst_b), .adv_valid(adv_valid),
    .adv_channel(adv_channel), .adv_ph(adv_ph), .adv_pd(adv_pd), .adv_nph(adv_nph),
    .adv_npd(adv_npd), .adv_cplh(adv_cplh), .adv_cpld(adv_cpld),
    .adv_cpl_infinite(adv_cpl_infinite));

  // one compare, counted; an unknown never counts as a match
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // pulse start, then expect four back-to-back advertisements two edges later;
  // only the three configurable fields may pass, the rest must read zero
  task automatic run_init();
    logic [55:0] exp;
    int          base;
    base = u_rfca_link_partner.n_adv;
    @(negedge clk) fc_init_start = 1'b1;
    @(negedge clk) fc_init_start = 1'b0;
    check(adv_valid === 1'b0, "advertisement too early");
    for (int c = 0; c < 4; c++) begin
      @(negedge clk);
      exp = {28'h0, v[c][27:0]};
      check(adv_valid === 1'b1 && adv_channel === c[1:0], "channel order");
      check({adv_cpld, adv_cplh, adv_npd, adv_nph, adv_pd, adv_ph} === exp, "fields");
      check(adv_cpl_infinite === 1'b1 && rx_cpl_ready === 1'b1, "completions limited");
    end
    check(fc_init_done === 1'b1, "done not set");
    @(negedge clk);
    check(adv_valid === 1'b0 && fc_init_done === 1'b1, "extra advertisement");
    // the partner registers each advertisement one edge after it stands
    for (int k = 0; k < 4; k++) begin
      check(u_rfca_link_partner.seen[k] === {28'h0, v[k][27:0]}, "partner capture");
    end
    check(u_rfca_link_partner.n_adv == base + 4, "advertisement count");
    check(u_rfca_link_partner.proto_bad === 1'b0, "partner saw bad sequence");
  endtask

  task automatic test_reset();
    check(rx_cpl_ready === 1'b1 && adv_valid === 1'b0, "reset outputs");
    check(fc_init_done === 1'b0 && cfg_fault === 1'b0, "reset flags");
  endtask

  // boundary values in every configurable field
  task automatic test_clean();
    v[0] = 56'h00_0000_0fff_ffff;
    v[1] = 56'h00_0000_0123_4501;
    v[2] = 56'h00_0000_0800_1080;
    v[3] = 56'h00_0000_0a5f_ff5a;
    @(negedge clk);
    @(negedge clk);
    check(cfg_fault === 1'b0, "fault on clean vectors");
    run_init();
  endtask

  // each must-be-zero field set alone flags a fault; all set, none advertised
  task automatic test_forced();
    logic [55:0] bad [4];
    bad = '{56'h00_0000_1000_0000, 56'h00_0008_0000_0000, 56'h00_0ff0_0000_0000,
            56'h80_0000_0000_0000};
    for (int c = 0; c < 4; c++) begin
      v[c] = v[c] | bad[c];
      @(negedge clk);
      @(negedge clk);
      check(cfg_fault === 1'b1, "bad field not flagged");
      v[c] = v[c] & ~bad[c];
      @(negedge clk);
      @(negedge clk);
      check(cfg_fault === 1'b0, "fault stuck");
    end
    // set every bad field at once only after each was seen clearing alone
    for (int c = 0; c < 4; c++) begin
      v[c] = v[c] | bad[c];
    end
    @(negedge clk);
    @(negedge clk);
    check(cfg_fault === 1'b1, "fault lost with all fields set");
    run_init();
  endtask

  // a span far beyond the roughly fifty cycles the tests need
  initial begin
    #20000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    test_reset();
    test_clean();
    test_forced();
    finish_test();
  end
endmodule
